/* hw/mdpc_pkg.sv */
// Constants and state types for the parallel configuration master.
// Assumes a 100 MHz system clock and a separate oscillator-driven link clock.
package mdpc_pkg;
   // ********************************************************
   // Timing
   // ********************************************************
   localparam int CLK_MHZ = 100;
   localparam int REQ_MIN_NS = 500;
   localparam int REQ_MIN_CYC = (REQ_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int REQ_CNT_W = 8;
   localparam int ACC_CYC = 4;
   localparam int ACC_W = 3;
   // ********************************************************
   // Flash bus layout
   // ********************************************************
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 16;
   localparam logic [ADDR_W-1:0] BOOT_ADDR = 24'h010000;
   localparam int FIFO_DEPTH = 32;
   // ********************************************************
   // State types
   // ********************************************************
   typedef enum logic [2:0] {C_OFF, C_LOAD, C_WAIT, C_INIT, C_USER} mdpc_ctl_e;
   typedef enum logic [1:0] {L_IDLE, L_ADDR, L_DATA, L_END} mdpc_lnk_e;
endpackage : mdpc_pkg

/* hw/mdpc_fifo.sv */
// Single-clock FIFO between the flash reader and the slave streamer.
// Assumes one clock domain; clr empties it synchronously.
`timescale 1ns/1ps
module mdpc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic clr,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic full, empty, do_wr, do_rd;

   assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty = (wp_r == rp_r);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rp_r[AW-1:0]];
   assign do_wr = in_valid && !full && !clr;
   assign do_rd = out_ready && !empty && !clr;

   always_comb
   begin
      wp_nxt = do_wr ? wp_r + 1'b1 : wp_r;
      rp_nxt = do_rd ? rp_r + 1'b1 : rp_r;
      if (clr)
      begin
         wp_nxt = '0;
         rp_nxt = '0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   always_ff @(posedge clk)
   begin
      if (do_wr)
         mem[wp_r[AW-1:0]] <= in_data;
   end
endmodule : mdpc_fifo

/* hw/mdpc_master.sv */
// Configuration master: reads the image from parallel flash, keeps its own
// part, streams the rest to passive-parallel slave chains.
// Assumes board pull-ups on the shared lines and a weak pull-down on the
// chain-enable input; open-drain pins are resolved outside.
`timescale 1ns/1ps
module mdpc_master #(
   parameter int MASTER_WORDS = 4,
   parameter int SLAVE_WORDS = 8,
   parameter int FIFO_DEPTH = mdpc_pkg::FIFO_DEPTH
) (
   // Clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic osc_clk,
   // Straps and negotiation pins
   input wire logic word_wide,
   input wire logic config_request_n,
   input wire logic chain_enable_in_n,
   output logic chain_enable_out_n,
   // Flash bus
   output logic [mdpc_pkg::ADDR_W-1:0] flash_addr,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_adv_n,
   output logic flash_we_n,
   output logic flash_rst_n,
   output logic flash_bus_oe,
   input wire logic [mdpc_pkg::DATA_W-1:0] flash_data,
   input wire logic flash_wait,
   // Configuration clock and slave lanes
   output logic config_clock,
   output logic config_clock_oe,
   output logic [mdpc_pkg::DATA_W-1:0] slave_data,
   output logic slave_data_oe,
   // Shared open-drain lines
   input wire logic shared_done_line_i,
   output logic shared_done_line_o,
   output logic shared_done_line_oe,
   input wire logic shared_status_line_i,
   output logic shared_status_line_o,
   output logic shared_status_line_oe,
   // Status
   output logic init_start,
   output logic user_mode,
   output logic user_wait
);
   localparam int TOTAL = MASTER_WORDS + SLAVE_WORDS;
   localparam logic [mdpc_pkg::CNT_W-1:0] MW = mdpc_pkg::CNT_W'(MASTER_WORDS);
   localparam logic [mdpc_pkg::CNT_W-1:0] SW = mdpc_pkg::CNT_W'(SLAVE_WORDS);
   localparam logic [mdpc_pkg::CNT_W-1:0] LAST = mdpc_pkg::CNT_W'(TOTAL - 1);
   localparam logic [mdpc_pkg::REQ_CNT_W-1:0] REQ_MAX =
      mdpc_pkg::REQ_CNT_W'(mdpc_pkg::REQ_MIN_CYC);
   localparam logic [mdpc_pkg::ACC_W-1:0] ACC_LAST = mdpc_pkg::ACC_W'(mdpc_pkg::ACC_CYC - 1);

   if (MASTER_WORDS < 1 || SLAVE_WORDS < 1 || TOTAL >= (1 << mdpc_pkg::CNT_W)
       || mdpc_pkg::REQ_MIN_CYC >= (1 << mdpc_pkg::REQ_CNT_W)) begin : g_chk
      $error("Word counts out of range");
   end

   // ********************************************************
   // System domain: pin synchronisers
   // ********************************************************
   logic [5:0] s1_r, s2_r;
   logic own_l_r, str_l_r;
   logic req_n_s, ce_in_s, done_s, wait_s, own_s, str_s;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= '0;
         s2_r <= '0;
      end
      else
      begin
         s1_r <= {str_l_r, own_l_r, flash_wait, shared_done_line_i, chain_enable_in_n,
                  config_request_n};
         s2_r <= s1_r;
      end
   end
   assign {str_s, own_s, wait_s, done_s, ce_in_s, req_n_s} = s2_r;

   // ********************************************************
   // System domain: configuration sequencer
   // ********************************************************
   mdpc_pkg::mdpc_ctl_e st_r, st_nxt;
   logic [mdpc_pkg::REQ_CNT_W-1:0] req_cnt_r, req_cnt_nxt;
   logic req_long, run_r, run_nxt, done_oe_r, done_oe_nxt, stat_oe_r, stat_oe_nxt;
   logic init_r, init_nxt, user_r, user_nxt, uwait_r, uwait_nxt;

   assign req_long = (req_cnt_r == REQ_MAX);

   always_comb
   begin
      req_cnt_nxt = req_n_s ? '0 : (req_long ? req_cnt_r : req_cnt_r + 1'b1);
      st_nxt = st_r;
      case (st_r)
         mdpc_pkg::C_OFF: if (req_n_s && !ce_in_s) st_nxt = mdpc_pkg::C_LOAD;
         mdpc_pkg::C_LOAD: if (own_s) st_nxt = mdpc_pkg::C_WAIT;
         mdpc_pkg::C_WAIT: if (done_s && str_s) st_nxt = mdpc_pkg::C_INIT;
         mdpc_pkg::C_INIT: st_nxt = mdpc_pkg::C_USER;
         mdpc_pkg::C_USER: st_nxt = mdpc_pkg::C_USER;
         default: st_nxt = mdpc_pkg::C_OFF;
      endcase
      if ((st_r == mdpc_pkg::C_LOAD || st_r == mdpc_pkg::C_WAIT) && ce_in_s)
         st_nxt = mdpc_pkg::C_OFF;
      if (req_long)
         st_nxt = mdpc_pkg::C_OFF;
      run_nxt = (st_nxt == mdpc_pkg::C_LOAD) || (st_nxt == mdpc_pkg::C_WAIT);
      done_oe_nxt = (st_nxt == mdpc_pkg::C_OFF) || (st_nxt == mdpc_pkg::C_LOAD);
      stat_oe_nxt = (st_nxt == mdpc_pkg::C_OFF);
      init_nxt = (st_nxt == mdpc_pkg::C_INIT);
      user_nxt = (st_nxt == mdpc_pkg::C_USER);
      uwait_nxt = user_nxt && wait_s;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= mdpc_pkg::C_OFF;
         req_cnt_r <= '0;
         run_r <= 1'b0;
         done_oe_r <= 1'b1;
         stat_oe_r <= 1'b1;
         init_r <= 1'b0;
         user_r <= 1'b0;
         uwait_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         req_cnt_r <= req_cnt_nxt;
         run_r <= run_nxt;
         done_oe_r <= done_oe_nxt;
         stat_oe_r <= stat_oe_nxt;
         init_r <= init_nxt;
         user_r <= user_nxt;
         uwait_r <= uwait_nxt;
      end
   end

   // Open-drain lines only ever drive low
   assign shared_done_line_o = 1'b0;
   assign shared_status_line_o = 1'b0;
   assign shared_done_line_oe = done_oe_r;
   assign shared_status_line_oe = stat_oe_r;
   assign init_start = init_r;
   assign user_mode = user_r;
   assign user_wait = uwait_r;

   a_req_reset_bus: assert property (@(posedge clk) disable iff (rst)
      req_long |=> !run_r && st_r == mdpc_pkg::C_OFF)
      else $error("Long config request did not stop loading");
   a_done_held_low: assert property (@(posedge clk) disable iff (rst)
      (st_r == mdpc_pkg::C_LOAD) ##1 (st_r == mdpc_pkg::C_LOAD) |-> done_oe_r)
      else $error("Done line released before own data");
   a_init_on_done: assert property (@(posedge clk) disable iff (rst)
      $rose(init_r) |-> $past(done_s) && ($past(st_r) == mdpc_pkg::C_WAIT))
      else $error("Initialization without shared done high");
   a_wait_user_only: assert property (@(posedge clk) disable iff (rst)
      !user_r |-> !uwait_r)
      else $error("Flash wait reported outside user mode");
   a_status_pull: assert property (@(posedge clk) disable iff (rst)
      (st_r == mdpc_pkg::C_OFF) [*2] |-> stat_oe_r && done_oe_r)
      else $error("Shared lines not pulled low while off");

   // ********************************************************
   // Link domain: reset release and synchronisers
   // ********************************************************
   logic lr1_r, lrst;
   logic [1:0] l1_r, l2_r;
   logic [mdpc_pkg::DATA_W-1:0] fd1_r, fd2_r;
   logic run_l, word_l;

   always_ff @(posedge osc_clk or posedge rst)
   begin
      if (rst)
      begin
         lr1_r <= 1'b1;
         lrst <= 1'b1;
      end
      else
      begin
         lr1_r <= 1'b0;
         lrst <= lr1_r;
      end
   end

   always_ff @(posedge osc_clk or posedge lrst)
   begin
      if (lrst)
      begin
         l1_r <= '0;
         l2_r <= '0;
         fd1_r <= '0;
         fd2_r <= '0;
      end
      else
      begin
         l1_r <= {word_wide, run_r};
         l2_r <= l1_r;
         fd1_r <= flash_data;
         fd2_r <= fd1_r;
      end
   end
   assign {word_l, run_l} = l2_r;

   // ********************************************************
   // Link domain: flash reader
   // ********************************************************
   mdpc_pkg::mdpc_lnk_e lst_r, lst_nxt;
   logic [mdpc_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic [mdpc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [mdpc_pkg::ACC_W-1:0] acc_r, acc_nxt;
   logic own_nxt, push_c, f_in_ready, f_out_valid, pop_c;
   logic [mdpc_pkg::DATA_W-1:0] f_out_data;

   // Flash wait is never sampled here: accesses are fixed length
   always_comb
   begin
      lst_nxt = lst_r;
      addr_nxt = addr_r;
      cnt_nxt = cnt_r;
      acc_nxt = acc_r;
      push_c = 1'b0;
      case (lst_r)
         mdpc_pkg::L_IDLE:
            if (run_l)
            begin
               lst_nxt = mdpc_pkg::L_ADDR;
               addr_nxt = mdpc_pkg::BOOT_ADDR;
               cnt_nxt = '0;
            end
         mdpc_pkg::L_ADDR:
         begin
            lst_nxt = mdpc_pkg::L_DATA;
            acc_nxt = '0;
         end
         mdpc_pkg::L_DATA:
            if (acc_r != ACC_LAST)
               acc_nxt = acc_r + 1'b1;
            else if (cnt_r < MW || f_in_ready)
            begin
               push_c = (cnt_r >= MW);
               cnt_nxt = cnt_r + 1'b1;
               addr_nxt = addr_r + 1'b1;
               lst_nxt = (cnt_r == LAST) ? mdpc_pkg::L_END : mdpc_pkg::L_ADDR;
            end
         mdpc_pkg::L_END: lst_nxt = mdpc_pkg::L_END;
         default: lst_nxt = mdpc_pkg::L_IDLE;
      endcase
      if (!run_l)
      begin
         lst_nxt = mdpc_pkg::L_IDLE;
         push_c = 1'b0;
      end
      own_nxt = run_l && (cnt_nxt >= MW);
   end

   mdpc_fifo #(.WIDTH(mdpc_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(osc_clk),
      .rst(lrst),
      .clr(!run_l),
      .in_valid(push_c),
      .in_ready(f_in_ready),
      .in_data(fd2_r),
      .out_valid(f_out_valid),
      .out_ready(pop_c),
      .out_data(f_out_data)
   );

   // ********************************************************
   // Link domain: configuration clock and slave streamer
   // ********************************************************
   logic ccl_r, ccl_nxt, pend_r, pend_nxt, half_r, half_nxt, str_nxt;
   logic [mdpc_pkg::DATA_W-1:0] sd_r, sd_nxt;
   logic [mdpc_pkg::CNT_W-1:0] sent_r, sent_nxt;
   logic [mdpc_pkg::ADDR_W-1:0] fa_r;
   logic fce_n_r, foe_n_r, fadv_n_r, boe_r, slv_oe_r;

   always_comb
   begin
      ccl_nxt = ccl_r;
      pend_nxt = pend_r;
      half_nxt = half_r;
      sd_nxt = sd_r;
      pop_c = 1'b0;
      if (ccl_r)
         ccl_nxt = 1'b0;
      else if (pend_r)
      begin
         ccl_nxt = 1'b1;
         pend_nxt = 1'b0;
      end
      else if (f_out_valid && own_l_r)
      begin
         pend_nxt = 1'b1;
         if (word_l)
         begin
            sd_nxt = f_out_data;
            pop_c = 1'b1;
         end
         else
         begin
            sd_nxt = {8'h00, half_r ? f_out_data[15:8] : f_out_data[7:0]};
            half_nxt = !half_r;
            pop_c = half_r;
         end
      end
      if (!run_l)
      begin
         ccl_nxt = 1'b0;
         pend_nxt = 1'b0;
         half_nxt = 1'b0;
         pop_c = 1'b0;
      end
      sent_nxt = !run_l ? '0 : (pop_c ? sent_r + 1'b1 : sent_r);
      str_nxt = run_l && (sent_r == SW) && !pend_r && !ccl_r;
   end

   always_ff @(posedge osc_clk or posedge lrst)
   begin
      if (lrst)
      begin
         lst_r <= mdpc_pkg::L_IDLE;
         addr_r <= '0;
         cnt_r <= '0;
         acc_r <= '0;
         own_l_r <= 1'b0;
         ccl_r <= 1'b0;
         pend_r <= 1'b0;
         half_r <= 1'b0;
         sd_r <= '0;
         sent_r <= '0;
         str_l_r <= 1'b0;
         fa_r <= '0;
         fce_n_r <= 1'b1;
         foe_n_r <= 1'b1;
         fadv_n_r <= 1'b1;
         boe_r <= 1'b0;
         slv_oe_r <= 1'b0;
      end
      else
      begin
         lst_r <= lst_nxt;
         addr_r <= addr_nxt;
         cnt_r <= cnt_nxt;
         acc_r <= acc_nxt;
         own_l_r <= own_nxt;
         ccl_r <= ccl_nxt;
         pend_r <= pend_nxt;
         half_r <= half_nxt;
         sd_r <= sd_nxt;
         sent_r <= sent_nxt;
         str_l_r <= str_nxt;
         fa_r <= addr_nxt;
         fce_n_r <= !(lst_nxt == mdpc_pkg::L_ADDR || lst_nxt == mdpc_pkg::L_DATA);
         foe_n_r <= !(lst_nxt == mdpc_pkg::L_DATA);
         fadv_n_r <= !(lst_nxt == mdpc_pkg::L_ADDR);
         boe_r <= run_l;
         slv_oe_r <= run_l && own_nxt;
      end
   end

   assign chain_enable_out_n = !own_l_r;
   assign flash_addr = fa_r;
   assign flash_ce_n = fce_n_r;
   assign flash_oe_n = foe_n_r;
   assign flash_adv_n = fadv_n_r;
   assign flash_we_n = 1'b1;
   assign flash_rst_n = boe_r;
   assign flash_bus_oe = boe_r;
   assign config_clock = ccl_r;
   assign config_clock_oe = boe_r;
   assign slave_data = sd_r;
   assign slave_data_oe = slv_oe_r;

   a_bus_tristate: assert property (@(posedge osc_clk) disable iff (lrst)
      !run_l |=> !flash_bus_oe && !config_clock_oe && !slave_data_oe)
      else $error("Bus driven without configuration run");
   a_chain_enable: assert property (@(posedge osc_clk) disable iff (lrst)
      $fell(chain_enable_out_n) |-> cnt_r == MW)
      else $error("Chain enable not at end of own data");
   a_byte_lane: assert property (@(posedge osc_clk) disable iff (lrst)
      $rose(ccl_r) && !word_l |-> sd_r[15:8] == 8'h00)
      else $error("High lane used in byte-wide mode");
   a_slave_gate: assert property (@(posedge osc_clk) disable iff (lrst)
      $rose(ccl_r) |-> !chain_enable_out_n && slave_data_oe)
      else $error("Slave clocked while chain not enabled");
   a_clock_divider: assert property (@(posedge osc_clk) disable iff (lrst)
      ccl_r |=> !ccl_r ##1 !ccl_r)
      else $error("Configuration clock high too long");
endmodule : mdpc_master

/* dv/mdpc_flash_model.sv */
// Far-side model: parallel flash image and the passive-parallel slave chains.
// Assumes the master drives address and controls; done line resolved by the bench.
`timescale 1ns/1ps
module mdpc_flash_model #(
   parameter int MASTER_WORDS = 4,
   parameter int SLAVE_WORDS = 8
) (
   // Flash pins
   input wire logic [mdpc_pkg::ADDR_W-1:0] flash_addr,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   output logic [15:0] flash_data,
   // Slave chain pins
   input wire logic config_clock,
   input wire logic [15:0] slave_data,
   input wire logic chain_enable_n,
   input wire logic word_wide,
   // Bench controls and results
   input wire logic hold_done,
   input wire logic clr,
   output logic done_pull,
   output logic [15:0] units,
   output logic [15:0] bad
);
   // ********************************************************
   // Flash read port
   // ********************************************************
   logic [15:0] last_q = 16'h0000;
   logic [15:0] need;
   logic [15:0] exp_w;
   logic [15:0] exp_u;
   always @(posedge flash_oe_n)
      last_q = flash_addr[15:0] ^ 16'h5A3C;
   // Released bus shows the inverse of the last word
   always_comb
   begin
      if (!flash_ce_n && !flash_oe_n)
         flash_data = flash_addr[15:0] ^ 16'h5A3C;
      else
         flash_data = ~last_q;
   end
   // ********************************************************
   // Slave chains
   // ********************************************************
   assign need = word_wide ? 16'(SLAVE_WORDS) : 16'(2 * SLAVE_WORDS);
   // Slaves strapped passive-parallel: take lane data on clock rise
   // Slaves still waiting for data pull the done line low
   assign done_pull = hold_done || (units < need);
   always @(posedge config_clock or posedge clr)
   begin
      if (clr)
      begin
         units <= 16'h0000;
         bad <= 16'h0000;
      end
      else
      begin
         exp_w = (mdpc_pkg::BOOT_ADDR[15:0] + 16'(MASTER_WORDS)
                  + (word_wide ? units : units >> 1)) ^ 16'h5A3C;
         if (word_wide)
            exp_u = exp_w;
         else
            exp_u = {8'h00, units[0] ? exp_w[15:8] : exp_w[7:0]};
         if (chain_enable_n || units >= need || slave_data !== exp_u)
            bad <= bad + 16'h0001;
         units <= units + 16'h0001;
      end
   end
endmodule : mdpc_flash_model

/* dv/multi_device_parallel_config_tb.sv */
// Self-checking bench for the parallel configuration master.
// Assumes the far-side model file and the design package are compiled first.
`timescale 1ns/1ps
module multi_device_parallel_config_tb;
   localparam int MW = 4;
   localparam int SW = 8;
   logic clk, rst, osc_clk, word_wide, config_request_n, chain_enable_in_n;
   logic flash_wait, hold_done, clr, done_pull;
   logic chain_enable_out_n, flash_ce_n, flash_oe_n, flash_bus_oe, config_clock;
   logic config_clock_oe, slave_data_oe, done_o, done_oe, stat_o, stat_oe;
   logic init_start, user_mode, user_wait, done_w, stat_w;
   logic flash_adv_n, flash_we_n, flash_rst_n;
   logic [mdpc_pkg::ADDR_W-1:0] flash_addr;
   logic [15:0] flash_data, slave_data, units, bad;
   int err_count = 0;
   int total_checks = 0;
   // Open-drain lines with board pull-ups
   assign done_w = ~((done_oe & ~done_o) | done_pull);
   assign stat_w = ~(stat_oe & ~stat_o);

   mdpc_master #(.MASTER_WORDS(MW), .SLAVE_WORDS(SW), .FIFO_DEPTH(32)) dut_u (
      .clk(clk), .rst(rst), .osc_clk(osc_clk), .word_wide(word_wide),
      .config_request_n(config_request_n), .chain_enable_in_n(chain_enable_in_n),
      .chain_enable_out_n(chain_enable_out_n), .flash_addr(flash_addr),
      .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_adv_n(flash_adv_n),
      .flash_we_n(flash_we_n), .flash_rst_n(flash_rst_n), .flash_bus_oe(flash_bus_oe),
      .flash_data(flash_data), .flash_wait(flash_wait), .config_clock(config_clock),
      .config_clock_oe(config_clock_oe), .slave_data(slave_data),
      .slave_data_oe(slave_data_oe), .shared_done_line_i(done_w),
      .shared_done_line_o(done_o), .shared_done_line_oe(done_oe),
      .shared_status_line_i(stat_w), .shared_status_line_o(stat_o),
      .shared_status_line_oe(stat_oe), .init_start(init_start),
      .user_mode(user_mode), .user_wait(user_wait));

   mdpc_flash_model #(.MASTER_WORDS(MW), .SLAVE_WORDS(SW)) partner_u (
      .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
      .flash_data(flash_data), .config_clock(config_clock), .slave_data(slave_data),
      .chain_enable_n(chain_enable_out_n), .word_wide(word_wide),
      .hold_done(hold_done), .clr(clr), .done_pull(done_pull), .units(units), .bad(bad));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      osc_clk = 1'b0;
      #3.7;
      forever
      begin
         osc_clk = ~osc_clk;
         #62.5;
      end
   end
   // ********************************************************
   // Common tasks
   // ********************************************************
   task end_sim;
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
         err_count++;
      end
   endtask : chk

   task tick(input int n);
      repeat (n)
      begin
         @(posedge clk);
         #1;
      end
   endtask : tick

   task wait_init(input int bound);
      int i;
      i = 0;
      while (init_start !== 1'b1)
      begin
         if (i == bound)
         begin
            chk(16'(init_start), 16'h0001);
            end_sim();
         end
         tick(1);
         i++;
      end
   endtask : wait_init

   task wait_units(input logic [15:0] n);
      int i;
      i = 0;
      while ((units >= n) !== 1'b1)
      begin
         if (i == 9000)
         begin
            chk(units, n);
            end_sim();
         end
         tick(1);
         i++;
      end
   endtask : wait_units

   // Request held low long enough, bus checked while the loader is off
   task long_req;
      config_request_n = 1'b0;
      clr = 1'b1;
      tick(120);
      chk(16'(flash_bus_oe), 16'h0000);
      chk(16'(config_clock_oe), 16'h0000);
      chk(16'(slave_data_oe), 16'h0000);
      chk(16'(flash_ce_n), 16'h0001);
      chk(16'(flash_adv_n), 16'h0001);
      chk(16'(stat_w), 16'h0000);
      clr = 1'b0;
      config_request_n = 1'b1;
   endtask : long_req

   task full_result(input logic [15:0] n);
      tick(3);
      chk(16'(user_mode), 16'h0001);
      chk(units, n);
      chk(bad, 16'h0000);
      chk(16'(chain_enable_out_n), 16'h0000);
      chk(16'(done_oe), 16'h0000);
      chk(16'(done_w), 16'h0001);
   endtask : full_result
   // ********************************************************
   // Scenarios
   // ********************************************************
   task sc_byte_run;
      flash_wait = 1'b1;
      wait_init(9000);
      full_result(16'(2 * SW));
      chk(16'(user_wait), 16'h0001);
   endtask : sc_byte_run

   task sc_word_hold;
      word_wide = 1'b1;
      hold_done = 1'b1;
      long_req();
      wait_units(16'(SW));
      tick(200);
      chk(16'(user_mode), 16'h0000);
      chk(16'(done_w), 16'h0000);
      hold_done = 1'b0;
      wait_init(100);
      full_result(16'(SW));
   endtask : sc_word_hold

   task sc_req_reset;
      word_wide = 1'b0;
      long_req();
      wait_units(16'h0002);
      config_request_n = 1'b0;
      tick(30);
      config_request_n = 1'b1;
      tick(80);
      chk(16'(flash_bus_oe), 16'h0001);
      chk(16'(flash_rst_n), 16'h0001);
      chk(16'(flash_we_n), 16'h0001);
      long_req();
      wait_init(9000);
      full_result(16'(2 * SW));
   endtask : sc_req_reset

   task sc_takeover;
      long_req();
      wait_units(16'h0002);
      chain_enable_in_n = 1'b1;
      tick(100);
      chk(16'(flash_bus_oe), 16'h0000);
      chk(16'(config_clock_oe), 16'h0000);
      chain_enable_in_n = 1'b0;
      tick(1);
      long_req();
      wait_init(9000);
      full_result(16'(2 * SW));
   endtask : sc_takeover

   initial
   begin
      rst = 1'b1;
      clr = 1'b0;
      word_wide = 1'b0;
      config_request_n = 1'b1;
      chain_enable_in_n = 1'b0;
      flash_wait = 1'b0;
      hold_done = 1'b0;
      tick(1);
      clr = 1'b1;
      tick(5);
      rst = 1'b0;
      clr = 1'b0;
      sc_byte_run();
      sc_word_hold();
      sc_req_reset();
      sc_takeover();
      end_sim();
   end
endmodule : multi_device_parallel_config_tb
